// [common/tmc_pkg.sv]
// tmc_pkg: constants shared by the 16-bit timer/counter with input capture.
// assumes an 8-bit cpu i/o port with a 4-bit location index.
package tmc_pkg;
   // i/o locations (index into the timer's own 16-entry window)
   localparam logic [3:0] ADR_CTRL_A = 4'h0;
   localparam logic [3:0] ADR_CTRL_B = 4'h1;
   localparam logic [3:0] ADR_CNT_LO = 4'h4;
   localparam logic [3:0] ADR_CNT_HI = 4'h5;
   localparam logic [3:0] ADR_CAP_LO = 4'h6;
   localparam logic [3:0] ADR_CAP_HI = 4'h7;
   localparam logic [3:0] ADR_CMP_LO = 4'h8;
   localparam logic [3:0] ADR_CMP_HI = 4'h9;
   localparam logic [3:0] ADR_FLAGS = 4'hA;
   localparam logic [3:0] ADR_MASK = 4'hB;

   // field positions
   localparam int CA_WGM_LSB = 0;
   localparam int CB_CS_LSB = 0;
   localparam int CB_WGM_LSB = 3;
   localparam int CB_EDGE_BIT = 6;
   localparam int CB_NOISE_BIT = 7;
   localparam int FLAG_OVF_BIT = 0;
   localparam int FLAG_CAP_BIT = 5;

   // reset values
   localparam logic [7:0] BYTE_RST = 8'h00;
   localparam logic [15:0] WORD_RST = 16'h0000;
   localparam logic [3:0] SHIFT_RST = 4'h0;

   // clock-source select codes
   localparam logic [2:0] CS_NONE = 3'h0;
   localparam logic [2:0] CS_DIV1 = 3'h1;
   localparam logic [2:0] CS_PRE_FIRST = 3'h2;
   localparam logic [2:0] CS_PRE_LAST = 3'h5;
   localparam logic [2:0] CS_EXT_FALL = 3'h6;
   localparam logic [2:0] CS_EXT_RISE = 3'h7;

   // fixed count limits
   localparam logic [15:0] CNT_MAX = 16'hFFFF;
   localparam logic [15:0] CNT_BOTTOM = 16'h0000;
   localparam logic [15:0] TOP_8BIT = 16'h00FF;
   localparam logic [15:0] TOP_9BIT = 16'h01FF;
   localparam logic [15:0] TOP_10BIT = 16'h03FF;

   // noise filter length in system clock samples
   localparam int FILT_SAMPLES = 4;
endpackage

// [dv/tmc_host_model.sv]
// tmc_host_model: cpu bus and event pins seen from outside the timer.
// assumes one calling process; every change lands on a falling edge.
`timescale 1ns/1ps
module tmc_host_model (
   input wire logic clk_i,
   input wire logic [7:0] rdata_i,
   output logic [3:0] addr_o,
   output logic [7:0] wdata_o,
   output logic wr_o,
   output logic rd_o,
   output logic cap_pin_o,
   output logic cmp_out_o,
   output logic cmp_sel_o,
   output logic ovf_ack_o,
   output logic cap_ack_o
);
   initial begin
      {addr_o, wdata_o, wr_o, rd_o} = '0;
      {cap_pin_o, cmp_out_o, cmp_sel_o, ovf_ack_o, cap_ack_o} = '0;
   end
   // released lines flip so a stale value never looks live
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(negedge clk_i);
      addr_o <= a;
      wdata_o <= d;
      wr_o <= 1'b1;
      @(negedge clk_i);
      wr_o <= 1'b0;
      addr_o <= ~a;
      wdata_o <= ~d;
   endtask
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(negedge clk_i);
      addr_o <= a;
      rd_o <= 1'b1;
      @(negedge clk_i);
      rd_o <= 1'b0;
      addr_o <= ~a;
      d = rdata_i;
   endtask
   // nothing else runs between the two halves, so the latch stays ours
   task automatic wr16(input logic [3:0] lo, input logic [15:0] v);
      wr(lo + 4'h1, v[15:8]);
      wr(lo, v[7:0]);
   endtask
   task automatic rd16(input logic [3:0] lo, output logic [15:0] v);
      rd(lo, v[7:0]);
      rd(lo + 4'h1, v[15:8]);
   endtask
   task automatic pins(input logic cap, input logic cmp, input logic sel);
      @(negedge clk_i);
      cap_pin_o <= cap;
      cmp_out_o <= cmp;
      cmp_sel_o <= sel;
   endtask
   task automatic ack(input logic ovf, input logic cap);
      @(negedge clk_i);
      ovf_ack_o <= ovf;
      cap_ack_o <= cap;
      @(negedge clk_i);
      ovf_ack_o <= 1'b0;
      cap_ack_o <= 1'b0;
   endtask
endmodule

// [dv/tmc_timer16_test.sv]
// tmc_timer16_test: self-checking bench for the timer with input capture.
// assumes the host model owns the cpu bus and the event pins.
`timescale 1ns/1ps
module tmc_timer16_test;
   import tmc_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] rdata, wdata, b;
   logic [3:0] addr;
   logic wr, rd, cap_pin, cmp_out, cmp_sel, ovf_ack, cap_ack;
   logic ovf_irq, cap_irq;
   logic [15:0] count, w;
   int errors = 0;
   int cmp_count = 0;
   int cycles = 0;
   // bit 12 set: read, low byte is the expected value; else a write
   logic [12:0] rows [22];
   logic [7:0] ma [3] = '{8'h01, 8'h01, 8'h00};
   logic [7:0] mb [3] = '{8'h01, 8'h09, 8'h01};
   logic [15:0] me [3] = '{16'h00FE, 16'h0000, 16'h0100};

   tmc_timer16 tmc_timer16_i (
      .CLK_SYS_I(clk), .SYS_RST_I(rst), .CE_I(1'b1),
      .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd),
      .RDATA_O(rdata), .PRESC_TICK_I(4'h0), .EXT_COUNT_PIN_I(1'b0),
      .CAPTURE_PIN_I(cap_pin), .COMPARATOR_OUTPUT_I(cmp_out),
      .COMPARATOR_CAPTURE_SELECT_I(cmp_sel), .OVF_ACK_I(ovf_ack),
      .CAP_ACK_I(cap_ack), .OVF_IRQ_O(ovf_irq), .CAP_IRQ_O(cap_irq),
      .COUNT_VALUE_O(count));

   tmc_host_model tmc_host_model_i (
      .clk_i(clk), .rdata_i(rdata), .addr_o(addr), .wdata_o(wdata),
      .wr_o(wr), .rd_o(rd), .cap_pin_o(cap_pin), .cmp_out_o(cmp_out),
      .cmp_sel_o(cmp_sel), .ovf_ack_o(ovf_ack), .cap_ack_o(cap_ack));

   initial begin
      forever #10 clk = ~clk;
   end

   task automatic report_and_stop;
      if (errors == 0 && cmp_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic chk(input string n, input logic [15:0] seen,
                      input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", n, exp, seen);
      end
   endtask

   // a pin edge at the falling edge shows its flag n falling edges later
   task automatic irq_after(input int n, input logic exp);
      repeat (n - 1) @(negedge clk);
      chk("capture irq early", {15'h0, cap_irq}, 16'h0000);
      @(negedge clk);
      chk("capture irq", {15'h0, cap_irq}, {15'h0, exp});
   endtask

   always @(posedge clk) begin
      cycles++;
      if (cycles == 4000) begin
         errors++;
         report_and_stop();
      end
   end

   initial begin
      rows = '{{1'b0, ADR_CNT_HI, 8'hAB}, {1'b0, ADR_CNT_LO, 8'hCD},
         {1'b1, ADR_CNT_LO, 8'hCD}, {1'b0, ADR_CNT_HI, 8'h77},
         {1'b1, ADR_CNT_HI, 8'h77}, {1'b1, ADR_CNT_LO, 8'hCD},
         {1'b1, ADR_CNT_HI, 8'hAB}, {1'b0, ADR_CMP_HI, 8'h55},
         {1'b0, ADR_CMP_LO, 8'h66}, {1'b0, ADR_CNT_HI, 8'h3C},
         {1'b1, ADR_CMP_HI, 8'h55}, {1'b1, ADR_CMP_LO, 8'h66},
         {1'b0, ADR_CMP_LO, 8'h01}, {1'b1, ADR_CMP_HI, 8'h3C},
         {1'b0, ADR_CAP_HI, 8'h99}, {1'b0, ADR_CAP_LO, 8'h88},
         {1'b1, ADR_CAP_LO, 8'h00}, {1'b1, ADR_CAP_HI, 8'h00},
         {1'b1, 4'h3, 8'h00}, {1'b0, 4'h2, 8'h5A}, {1'b1, 4'h2, 8'h00},
         {1'b1, ADR_CTRL_B, BYTE_RST}};
      repeat (12) @(negedge clk);
      chk("reset count", count, WORD_RST);
      chk("reset irq", {14'h0, ovf_irq, cap_irq}, WORD_RST);
      chk("reset rdata", {8'h00, rdata}, WORD_RST);
      rst <= 1'b0;
      foreach (rows[i]) begin
         if (rows[i][12]) begin
            tmc_host_model_i.rd(rows[i][11:8], b);
            chk("table byte", {8'h00, b}, {8'h00, rows[i][7:0]});
         end else tmc_host_model_i.wr(rows[i][11:8], rows[i][7:0]);
      end
      for (int i = 0; i < 3; i++) begin
         tmc_host_model_i.wr(ADR_CTRL_B, 8'h00);
         tmc_host_model_i.wr(ADR_CTRL_A, ma[i]);
         tmc_host_model_i.wr16(ADR_CNT_LO, 16'h00F0);
         tmc_host_model_i.wr(ADR_CTRL_B, mb[i]);
         tmc_host_model_i.wr16(ADR_CNT_LO, 16'h00FD);
         repeat (3) @(negedge clk);
         chk("mode count", count, me[i]);
      end
      // count keeps running between the two byte reads
      tmc_host_model_i.wr16(ADR_CNT_LO, 16'h12FE);
      tmc_host_model_i.rd16(ADR_CNT_LO, w);
      chk("running read", w, 16'h12FF);
      tmc_host_model_i.wr(ADR_CTRL_B, 8'h00);
      tmc_host_model_i.wr(ADR_MASK, 8'h21);
      // earlier mode runs left the overflow flag set
      tmc_host_model_i.wr(ADR_FLAGS, 8'h01);
      chk("overflow clear", {15'h0, ovf_irq}, 16'h0000);
      tmc_host_model_i.wr16(ADR_CNT_LO, 16'hFFFD);
      tmc_host_model_i.wr(ADR_CTRL_B, 8'h01);
      for (int i = 0; i < 10 && ovf_irq !== 1'b1; i++) @(negedge clk);
      chk("overflow irq", {15'h0, ovf_irq}, 16'h0001);
      tmc_host_model_i.wr(ADR_CTRL_B, 8'h00);
      tmc_host_model_i.ack(1'b1, 1'b0);
      chk("overflow ack", {15'h0, ovf_irq}, 16'h0000);
      tmc_host_model_i.wr16(ADR_CNT_LO, 16'h4321);
      repeat (5) @(negedge clk);
      chk("stopped count", count, 16'h4321);
      tmc_host_model_i.wr(ADR_CTRL_B, 8'h40);
      tmc_host_model_i.pins(1'b1, 1'b0, 1'b0);
      irq_after(2, 1'b1);
      tmc_host_model_i.rd16(ADR_CAP_LO, w);
      chk("capture", w, 16'h4321);
      tmc_host_model_i.wr16(ADR_CNT_LO, 16'h5555);
      tmc_host_model_i.wr(ADR_FLAGS, 8'h20);
      chk("flag write clear", {15'h0, cap_irq}, 16'h0000);
      tmc_host_model_i.pins(1'b0, 1'b0, 1'b0);
      irq_after(6, 1'b0);
      tmc_host_model_i.pins(1'b1, 1'b0, 1'b0);
      irq_after(2, 1'b1);
      tmc_host_model_i.rd16(ADR_CAP_LO, w);
      chk("overwrite", w, 16'h5555);
      tmc_host_model_i.ack(1'b0, 1'b1);
      chk("capture ack", {15'h0, cap_irq}, 16'h0000);
      tmc_host_model_i.wr(ADR_CTRL_B, 8'hC0);
      tmc_host_model_i.pins(1'b0, 1'b0, 1'b0);
      repeat (10) @(negedge clk);
      tmc_host_model_i.pins(1'b1, 1'b0, 1'b0);
      repeat (2) @(negedge clk);
      tmc_host_model_i.pins(1'b0, 1'b0, 1'b0);
      irq_after(10, 1'b0);
      tmc_host_model_i.pins(1'b1, 1'b0, 1'b0);
      irq_after(6, 1'b1);
      tmc_host_model_i.wr(ADR_CTRL_B, 8'h40);
      tmc_host_model_i.pins(1'b1, 1'b0, 1'b1);
      repeat (5) @(negedge clk);
      tmc_host_model_i.wr(ADR_FLAGS, 8'h20);
      tmc_host_model_i.pins(1'b0, 1'b0, 1'b1);
      tmc_host_model_i.pins(1'b1, 1'b0, 1'b1);
      irq_after(6, 1'b0);
      tmc_host_model_i.pins(1'b1, 1'b1, 1'b1);
      irq_after(2, 1'b1);
      tmc_host_model_i.wr(ADR_CTRL_B, 8'h58);
      tmc_host_model_i.wr(ADR_FLAGS, 8'h20);
      tmc_host_model_i.wr16(ADR_CAP_LO, 16'h0ABC);
      tmc_host_model_i.pins(1'b1, 1'b0, 1'b1);
      tmc_host_model_i.pins(1'b1, 1'b1, 1'b1);
      irq_after(6, 1'b0);
      tmc_host_model_i.rd16(ADR_CAP_LO, w);
      chk("top capture", w, 16'h0ABC);
      report_and_stop();
   end
endmodule

// [verilog/tmc_noise_filter.sv]
// tmc_noise_filter: four-sample agreement filter on one trigger input.
// assumes the input is already synchronous to CLK_SYS_I.
`timescale 1ns/1ps
module tmc_noise_filter (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic sample_i,
   output logic filt_o
);
   import tmc_pkg::*;

   typedef struct packed {
      logic [FILT_SAMPLES-1:0] shift;
      logic out;
   } tmc_filt_st_t;

   tmc_filt_st_t st_r;
   tmc_filt_st_t st_nxt;

   always_comb begin
      st_nxt = st_r;
      st_nxt.shift = {st_r.shift[FILT_SAMPLES-2:0], sample_i};
      // judged on the window incl. this sample, so the delay is four clocks
      if (&st_nxt.shift) begin
         st_nxt.out = 1'b1;
      end else if (~|st_nxt.shift) begin
         st_nxt.out = 1'b0;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         st_r <= '0;
      end else if (ce_i) begin
         st_r <= st_nxt;
      end
   end

   assign filt_o = st_r.out;

   a_filter_agree: assert property (@(posedge clk_i) disable iff (rst_i)
      $changed(st_r.out) |-> (st_r.shift == {FILT_SAMPLES{st_r.out}}))
      else $error("filter output moved without four equal samples");
endmodule

// [verilog/tmc_timer16.sv]
// tmc_timer16: 16-bit timer/counter with input capture and shared high latch.
// assumes a cpu on an 8-bit i/o port; prescaler taps arrive as 1-cycle ticks.
`timescale 1ns/1ps
module tmc_timer16 (
   input wire logic CLK_SYS_I,
   input wire logic SYS_RST_I,
   input wire logic CE_I,
   input wire logic [3:0] ADDR_I,
   input wire logic [7:0] WDATA_I,
   input wire logic WR_I,
   input wire logic RD_I,
   output logic [7:0] RDATA_O,
   input wire logic [3:0] PRESC_TICK_I,
   input wire logic EXT_COUNT_PIN_I,
   input wire logic CAPTURE_PIN_I,
   input wire logic COMPARATOR_OUTPUT_I,
   input wire logic COMPARATOR_CAPTURE_SELECT_I,
   input wire logic OVF_ACK_I,
   input wire logic CAP_ACK_I,
   output logic OVF_IRQ_O,
   output logic CAP_IRQ_O,
   output logic [15:0] COUNT_VALUE_O
);
   import tmc_pkg::*;

   typedef struct packed {
      logic [7:0] ctrl_a;
      logic [7:0] ctrl_b;
      logic [7:0] mask;
      logic [7:0] hi_latch;
      logic [15:0] count;
      logic [15:0] capture;
      logic [15:0] compare;
      logic count_down;
      logic ovf_flag;
      logic cap_flag;
      logic ext_prev;
      logic trig_smp;
      logic trig_prev;
      logic [7:0] rdata;
   } tmc_st_t;

   tmc_st_t st_r;
   tmc_st_t st_nxt;

   logic [3:0] wgm;
   logic [2:0] csel;
   logic [15:0] top;
   logic dual_slope;
   logic fast_pwm;
   logic cap_is_top;
   logic tick;
   logic filt_out;
   logic trig_now;
   logic cap_evt;
   logic wr_cnt_lo;

   assign wgm = {st_r.ctrl_b[CB_WGM_LSB +: 2],
      st_r.ctrl_a[CA_WGM_LSB +: 2]};
   assign csel = st_r.ctrl_b[CB_CS_LSB +: 3];

   // sequence decode from the split mode field
   always_comb begin
      top = CNT_MAX;
      dual_slope = 1'b0;
      fast_pwm = 1'b0;
      cap_is_top = 1'b0;
      case (wgm)
         4'h1: begin top = TOP_8BIT; dual_slope = 1'b1; end
         4'h2: begin top = TOP_9BIT; dual_slope = 1'b1; end
         4'h3: begin top = TOP_10BIT; dual_slope = 1'b1; end
         4'h4: top = st_r.compare;
         4'h5: begin top = TOP_8BIT; fast_pwm = 1'b1; end
         4'h6: begin top = TOP_9BIT; fast_pwm = 1'b1; end
         4'h7: begin top = TOP_10BIT; fast_pwm = 1'b1; end
         4'h8, 4'hA: begin
            top = st_r.capture;
            dual_slope = 1'b1;
            cap_is_top = 1'b1;
         end
         4'h9, 4'hB: begin top = st_r.compare; dual_slope = 1'b1; end
         4'hC: begin top = st_r.capture; cap_is_top = 1'b1; end
         4'hE: begin
            top = st_r.capture;
            fast_pwm = 1'b1;
            cap_is_top = 1'b1;
         end
         4'hF: begin top = st_r.compare; fast_pwm = 1'b1; end
         default: top = CNT_MAX;
      endcase
   end

   // timer tick: none, system clock, prescaler taps or external pin edge
   always_comb begin
      case (csel)
         CS_NONE: tick = 1'b0;
         CS_DIV1: tick = 1'b1;
         CS_EXT_FALL: tick = st_r.ext_prev & ~EXT_COUNT_PIN_I;
         CS_EXT_RISE: tick = ~st_r.ext_prev & EXT_COUNT_PIN_I;
         default: tick = PRESC_TICK_I[2'(csel - CS_PRE_FIRST)];
      endcase
   end

   // the pin input is read as is, so the pin's own port driving it counts
   tmc_noise_filter u_filter (
      .clk_i(CLK_SYS_I),
      .rst_i(SYS_RST_I),
      .ce_i(CE_I),
      .sample_i(st_r.trig_smp),
      .filt_o(filt_out)
   );

   assign trig_now = st_r.ctrl_b[CB_NOISE_BIT] ?
      filt_out : st_r.trig_smp;
   // the edge detector stays live except in capture-as-top modes
   assign cap_evt = ~cap_is_top & (st_r.ctrl_b[CB_EDGE_BIT] ?
      (trig_now & ~st_r.trig_prev) : (~trig_now & st_r.trig_prev));
   assign wr_cnt_lo = WR_I && (ADDR_I == ADR_CNT_LO);

   always_comb begin
      st_nxt = st_r;
      st_nxt.ext_prev = EXT_COUNT_PIN_I;
      st_nxt.trig_smp = COMPARATOR_CAPTURE_SELECT_I ?
         COMPARATOR_OUTPUT_I : CAPTURE_PIN_I;
      st_nxt.trig_prev = trig_now;

      // counting; a cpu write below overrides this
      if (tick) begin
         if (dual_slope) begin
            if (!st_r.count_down) begin
               if (st_r.count >= top) begin
                  st_nxt.count_down = 1'b1;
                  st_nxt.count = st_r.count - 16'h0001;
               end else begin
                  st_nxt.count = st_r.count + 16'h0001;
               end
            end else if (st_r.count == CNT_BOTTOM) begin
               st_nxt.count_down = 1'b0;
               st_nxt.count = st_r.count + 16'h0001;
               st_nxt.ovf_flag = 1'b1;
            end else begin
               st_nxt.count = st_r.count - 16'h0001;
            end
         end else begin
            st_nxt.count_down = 1'b0;
            if (st_r.count == top) begin
               st_nxt.count = CNT_BOTTOM;
            end else begin
               st_nxt.count = st_r.count + 16'h0001;
            end
            if (fast_pwm ? (st_r.count == top) : (st_r.count == CNT_MAX)) begin
               st_nxt.ovf_flag = 1'b1;
            end
         end
      end

      // clearing first so a same-cycle set still wins
      if (OVF_ACK_I || (WR_I && ADDR_I == ADR_FLAGS &&
                        WDATA_I[FLAG_OVF_BIT])) begin
         st_nxt.ovf_flag = 1'b0;
      end
      if (CAP_ACK_I || (WR_I && ADDR_I == ADR_FLAGS &&
                        WDATA_I[FLAG_CAP_BIT])) begin
         st_nxt.cap_flag = 1'b0;
      end
      if (tick && st_nxt.ovf_flag != st_r.ovf_flag && !st_r.ovf_flag) begin
         st_nxt.ovf_flag = 1'b1;
      end
      if (tick && dual_slope && st_r.count_down &&
          st_r.count == CNT_BOTTOM) begin
         st_nxt.ovf_flag = 1'b1;
      end
      if (tick && !dual_slope &&
          (fast_pwm ? (st_r.count == top) : (st_r.count == CNT_MAX))) begin
         st_nxt.ovf_flag = 1'b1;
      end

      if (cap_evt) begin
         st_nxt.capture = st_r.count;
         st_nxt.cap_flag = 1'b1;
      end

      if (WR_I) begin
         case (ADDR_I)
            ADR_CTRL_A: st_nxt.ctrl_a = WDATA_I;
            ADR_CTRL_B: st_nxt.ctrl_b = WDATA_I;
            ADR_MASK: st_nxt.mask = WDATA_I;
            ADR_CNT_HI, ADR_CAP_HI, ADR_CMP_HI:
               st_nxt.hi_latch = WDATA_I;
            ADR_CNT_LO: begin
               st_nxt.count = {st_r.hi_latch, WDATA_I};
            end
            ADR_CAP_LO: begin
               if (cap_is_top) begin
                  st_nxt.capture = {st_r.hi_latch, WDATA_I};
               end
            end
            ADR_CMP_LO: st_nxt.compare = {st_r.hi_latch, WDATA_I};
            default: st_nxt.ctrl_a = st_nxt.ctrl_a;
         endcase
      end

      // read data is registered; an unmapped location reads zero
      if (RD_I) begin
         case (ADDR_I)
            ADR_CTRL_A: st_nxt.rdata = st_r.ctrl_a;
            ADR_CTRL_B: st_nxt.rdata = st_r.ctrl_b;
            ADR_MASK: st_nxt.rdata = st_r.mask;
            ADR_FLAGS: begin
               st_nxt.rdata = BYTE_RST;
               st_nxt.rdata[FLAG_OVF_BIT] = st_r.ovf_flag;
               st_nxt.rdata[FLAG_CAP_BIT] = st_r.cap_flag;
            end
            ADR_CNT_LO: begin
               st_nxt.rdata = st_r.count[7:0];
               st_nxt.hi_latch = st_r.count[15:8];
            end
            ADR_CAP_LO: begin
               st_nxt.rdata = st_r.capture[7:0];
               st_nxt.hi_latch = st_r.capture[15:8];
            end
            ADR_CNT_HI, ADR_CAP_HI: st_nxt.rdata = st_r.hi_latch;
            ADR_CMP_LO: st_nxt.rdata = st_r.compare[7:0];
            ADR_CMP_HI: st_nxt.rdata = st_r.compare[15:8];
            default: st_nxt.rdata = BYTE_RST;
         endcase
      end
   end

   always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         st_r <= '0;
      end else if (CE_I) begin
         st_r <= st_nxt;
      end
   end

   assign RDATA_O = st_r.rdata;
   assign COUNT_VALUE_O = st_r.count;
   assign OVF_IRQ_O = st_r.ovf_flag & st_r.mask[FLAG_OVF_BIT];
   assign CAP_IRQ_O = st_r.cap_flag & st_r.mask[FLAG_CAP_BIT];

   a_cap_copy_count: assert property (@(posedge CLK_SYS_I)
      disable iff (SYS_RST_I)
      (CE_I && cap_evt && !(WR_I && ADDR_I == ADR_CAP_LO))
      |=> (st_r.capture == $past(st_r.count)) && st_r.cap_flag)
      else $error("capture did not copy the count with its flag");

   a_cap_flag_set: assert property (@(posedge CLK_SYS_I)
      disable iff (SYS_RST_I)
      (CE_I && cap_evt && CAP_ACK_I) |=> st_r.cap_flag)
      else $error("capture flag lost against a clear");

   a_stop_no_tick: assert property (@(posedge CLK_SYS_I)
      disable iff (SYS_RST_I)
      (CE_I && csel == CS_NONE && !wr_cnt_lo) |=> $stable(st_r.count))
      else $error("count moved with no clock source");

   a_cpu_write_wins: assert property (@(posedge CLK_SYS_I)
      disable iff (SYS_RST_I)
      (CE_I && wr_cnt_lo && tick)
      |=> st_r.count == {$past(st_r.hi_latch), $past(WDATA_I)})
      else $error("count write did not beat the count");

   a_low_read_latch: assert property (@(posedge CLK_SYS_I)
      disable iff (SYS_RST_I)
      (CE_I && RD_I && ADDR_I == ADR_CNT_LO && !WR_I) ##1
      (CE_I && RD_I && ADDR_I == ADR_CNT_HI && !WR_I)
      |=> RDATA_O == $past(st_r.count[15:8], 2))
      else $error("high read did not return the latched count byte");

   a_cap_write_guard: assert property (@(posedge CLK_SYS_I)
      disable iff (SYS_RST_I)
      (CE_I && WR_I && ADDR_I == ADR_CAP_LO && !cap_is_top && !cap_evt)
      |=> $stable(st_r.capture))
      else $error("capture register written outside capture-top mode");

   a_cap_top_quiet: assert property (@(posedge CLK_SYS_I)
      disable iff (SYS_RST_I)
      cap_is_top |-> !cap_evt)
      else $error("capture fired in a capture-as-top mode");

   a_ovf_normal: assert property (@(posedge CLK_SYS_I)
      disable iff (SYS_RST_I)
      (CE_I && tick && wgm == 4'h0 && st_r.count == CNT_MAX && !wr_cnt_lo)
      |=> st_r.ovf_flag && st_r.count == CNT_BOTTOM)
      else $error("normal mode wrap did not set overflow");

   a_cmp_read_direct: assert property (@(posedge CLK_SYS_I)
      disable iff (SYS_RST_I)
      (CE_I && RD_I && ADDR_I == ADR_CMP_HI)
      |=> RDATA_O == $past(st_r.compare[15:8]))
      else $error("compare high read went through the latch");
endmodule
